// *** design/flash_pin_pkg.sv ***
// Constants, field layout and lane modes for the serial flash pin front end
// Summary of operation
// - Chip select high deselects the part and floats every data line.
// - After power-up nothing is accepted until chip select has fallen once.
// - Single mode captures serial_in on each rising serial clock edge.
// - Single mode drives serial_out, changing it on each falling serial clock edge.
// - Dual and quad lines capture on rising edges and drive on falling edges.
// - Quad transfers need quad_enable_bit; then lines 2 and 3 carry data.
// - Lines 0-1 serve single and dual; protect and pause sit on lines 2 and 3 while quad_enable_bit is clear.
// - Write protect low with status_protect_bits at 1 blocks status register writes.
// - Pause low while selected floats serial_out and ignores input and clock.
// - Releasing pause resumes the transfer exactly where it stopped.
// - With quad_enable_bit set the pause function is gone; pin is data_line_3.
// - Quad clear: a status bit picks pause or reset; quad set: neither.
// - Bus modes 0 and 3 both work, whatever the idle clock level.
// - Reset pin low clears transfer, handshake and arm state; config, turnaround and tx data keep their values.
// - pause_or_reset_select 0 (default) means pause, 1 means reset.
// - Reset pin held low about 1us aborts work; no command accepted meanwhile.
// - Pause starts/ends at pin edge if clock low, else after next falling edge.
package flash_pin_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int TURN_W = 6;

  localparam logic [ADDR_W-1:0] CFG_ADDR  = 5'h00;
  localparam logic [ADDR_W-1:0] TURN_ADDR = 5'h04;
  localparam logic [ADDR_W-1:0] TX_ADDR   = 5'h08;
  localparam logic [ADDR_W-1:0] RX_ADDR   = 5'h0C;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 5'h10;

  localparam int CFG_QE     = 0;
  localparam int CFG_PRS    = 1;
  localparam int CFG_LANE   = 2;
  localparam int CFG_SP     = 4;
  localparam int CFG_BP     = 6;
  localparam int CFG_TB     = 10;
  localparam int CFG_CMP    = 11;
  localparam int CFG_W      = 12;

  localparam logic [CFG_W-1:0]  CFG_RESET  = 12'h000;
  localparam logic [TURN_W-1:0] TURN_RESET = 6'h00;
  localparam logic [1:0]        SP_HW_LOCK = 2'h1;
  localparam logic [5:0]        PIN_SYNC_INIT = 6'h06;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2
  } lanes_t;

endpackage

// *** design/sync_2ff.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_2ff
#(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // Destination clock and synchronous reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1Q;

  // Only the second stage is visible outside
  always_ff @(posedge clk)
  begin
    if (!rstN)
    begin
      stage1Q <= INIT;
      dout    <= INIT;
    end
    else
    begin
      stage1Q <= din;
      dout    <= stage1Q;
    end
  end

endmodule // sync_2ff

// *** design/serial_flash_pin_interface.sv ***
// Serial flash pin front end: select, lanes, pause, protect and reset pin handling
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module serial_flash_pin_interface
  import flash_pin_pkg::*;
#(
  parameter int TURN_BITS = TURN_W
)
(
  // System clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [DATA_W-1:0]    regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [DATA_W-1:0]    regRdata,
  // Serial link
  input  wire logic                 serialClk,
  input  wire logic                 chipSelectN,
  input  wire logic [3:0]           dataLineIn,
  output logic      [3:0]           dataLineOut,
  output logic      [3:0]           dataLineOeN
);

  logic [CFG_W-1:0]     cfgQ;
  logic [TURN_BITS-1:0] turnQ;
  logic [7:0]           txDataQ;
  logic [7:0]           rxDataQ;
  logic                 rxValidQ;
  logic                 overrunQ;
  logic                 txEmptyQ;
  logic                 armedQ;
  logic                 csPrevQ;
  logic                 rxTogPrevQ;
  logic                 txTogPrevQ;
  logic                 holdS;
  logic                 rxTogS;
  logic                 txTogS;
  logic                 rstPinS;
  logic                 wpPinS;
  logic                 csS;
  logic                 quadEn;
  logic                 pauseFunc;
  logic                 resetFunc;
  logic                 hwRst;
  logic                 wpLocked;
  logic                 csFall;
  logic                 rxEvt;
  logic                 txEvt;
  logic                 wrCfg;
  logic                 rdRx;

  // Link domain
  logic [1:0]           laneS;
  logic                 quadS;
  logic [TURN_BITS-1:0] turnS;
  logic                 linkClr;
  logic                 hwPinLow;
  logic                 pauseIn;
  logic                 holdHiQ;
  logic                 holdEff;
  logic                 laneOk;
  logic [2:0]           stepBits;
  logic [3:0]           laneMask;
  logic                 driveNow;
  logic [TURN_BITS-1:0] clkCntQ;
  logic [7:0]           rxShiftQ;
  logic [7:0]           rxNext;
  logic [2:0]           rxCntQ;
  logic [3:0]           rxSum;
  logic                 captureEn;
  logic [7:0]           rxByteQ;
  logic                 rxTogQ;
  logic [7:0]           txShiftQ;
  logic [2:0]           txCntQ;
  logic [3:0]           txSum;
  logic [7:0]           curByte;
  logic [7:0]           curShifted;
  logic                 driveGo;
  logic                 driveQ;
  logic                 txTogQ;
  logic [3:0]           outQ;

  // Pins and toggles from the link side into the register clock
  sync_2ff #(.W(6), .INIT(PIN_SYNC_INIT)) pinSync (
    .clk  (mclk),
    .rstN (rst_n),
    .din  ({holdEff, rxTogQ, txTogQ, dataLineIn[3], dataLineIn[2], chipSelectN}),
    .dout ({holdS, rxTogS, txTogS, rstPinS, wpPinS, csS})
  );

  // Lane setup into the link clock; software changes it only while deselected
  sync_2ff #(.W(TURN_BITS + 3)) cfgSync (
    .clk  (serialClk),
    .rstN (1'b1),
    .din  ({cfgQ[CFG_LANE +: 2], quadEn, turnQ}),
    .dout ({laneS, quadS, turnS})
  );

  assign quadEn    = cfgQ[CFG_QE];
  assign pauseFunc = ~cfgQ[CFG_PRS] & ~quadEn;
  assign resetFunc = cfgQ[CFG_PRS] & ~quadEn;
  assign hwRst     = resetFunc & ~rstPinS;
  assign wpLocked  = ~quadEn & ~wpPinS & (cfgQ[CFG_SP +: 2] == SP_HW_LOCK);
  assign csFall    = csPrevQ & ~csS;
  assign rxEvt     = rxTogS ^ rxTogPrevQ;
  assign txEvt     = txTogS ^ txTogPrevQ;
  assign wrCfg     = regWr && (regAddr == CFG_ADDR);
  assign rdRx      = regRd && (regAddr == RX_ADDR);

  // Protection bits stay readable; array protection itself lives in the core
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cfgQ <= CFG_RESET;
    else if (wrCfg && !wpLocked)
      cfgQ <= regWdata[CFG_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      turnQ <= TURN_RESET;
    else if (regWr && (regAddr == TURN_ADDR))
      turnQ <= regWdata[TURN_BITS-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      txDataQ <= 8'h00;
    else if (regWr && (regAddr == TX_ADDR))
      txDataQ <= regWdata[7:0];
  end

  // Link took the byte: set wins over a same-cycle write
  always_ff @(posedge mclk)
  begin
    if (!rst_n || hwRst)
      txEmptyQ <= 1'b1;
    else if (txEvt)
      txEmptyQ <= 1'b1;
    else if (regWr && (regAddr == TX_ADDR))
      txEmptyQ <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      csPrevQ    <= 1'b0;
      rxTogPrevQ <= 1'b0;
      txTogPrevQ <= 1'b0;
    end
    else
    begin
      csPrevQ    <= csS;
      rxTogPrevQ <= rxTogS;
      txTogPrevQ <= txTogS;
    end
  end

  // Select sync and csPrevQ start low, so a select already low at power-up never arms
  always_ff @(posedge mclk)
  begin
    if (!rst_n || hwRst)
      armedQ <= 1'b0;
    else if (csFall)
      armedQ <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || hwRst)
    begin
      rxValidQ <= 1'b0;
      overrunQ <= 1'b0;
      rxDataQ  <= 8'h00;
    end
    else if (rxEvt && armedQ)
    begin
      rxDataQ  <= rxByteQ;
      rxValidQ <= 1'b1;
      if (rxValidQ && !rdRx)
        overrunQ <= 1'b1;
    end
    else if (rdRx)
    begin
      rxValidQ <= 1'b0;
      overrunQ <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      regRdata <= '0;
    else
    begin
      regRdata <= '0;
      if (regRd)
      begin
        case (regAddr)
          CFG_ADDR:  regRdata[CFG_W-1:0]     <= cfgQ;
          TURN_ADDR: regRdata[TURN_BITS-1:0] <= turnQ;
          TX_ADDR:   regRdata[7:0]           <= txDataQ;
          RX_ADDR:   regRdata[7:0]           <= rxDataQ;
          STAT_ADDR: regRdata[7:0]           <= {overrunQ, wpLocked, txEmptyQ, rxValidQ,
                                                 hwRst, holdS, armedQ, ~csS};
          default:   regRdata                <= '0;
        endcase
      end
    end
  end

  // Reset pin acts straight on the pin, ahead of every other input
  assign hwPinLow = resetFunc & ~dataLineIn[3];
  assign linkClr  = chipSelectN | hwPinLow | ~rst_n;
  assign pauseIn  = pauseFunc & ~dataLineIn[3];
  assign laneOk   = (laneS == LANE_SINGLE) || (laneS == LANE_DUAL) ||
                    ((laneS == LANE_QUAD) && quadS);
  assign driveNow = (turnS != '0) && (clkCntQ >= turnS);

  // An illegal lane code steps as single, but laneOk keeps it off the shifters
  assign stepBits = (laneS == LANE_QUAD) ? 3'h4 : (laneS == LANE_DUAL) ? 3'h2 : 3'h1;
  assign laneMask = (laneS == LANE_QUAD) ? 4'hF : (laneS == LANE_DUAL) ? 4'h3 : 4'h2;
  assign rxNext   = (laneS == LANE_QUAD) ? {rxShiftQ[3:0], dataLineIn[3:0]} :
                    (laneS == LANE_DUAL) ? {rxShiftQ[5:0], dataLineIn[1:0]} :
                                           {rxShiftQ[6:0], dataLineIn[0]};

  // Pause state met at the rising edge carries through the high half of the clock
  always_ff @(posedge serialClk or posedge linkClr)
  begin
    if (linkClr)
      holdHiQ <= 1'b0;
    else
      holdHiQ <= pauseIn;
  end

  // Clock low: pin edge acts at once; clock high: wait for the falling edge
  assign holdEff = pauseFunc & ~chipSelectN & (serialClk ? holdHiQ : ~dataLineIn[3]);

  assign captureEn = !pauseIn && laneOk && !driveNow && !chipSelectN && !hwPinLow;
  assign rxSum     = {1'b0, rxCntQ} + {1'b0, stepBits};

  // Works for either idle clock level since only edges inside a frame count
  always_ff @(posedge serialClk or posedge linkClr)
  begin
    if (linkClr)
    begin
      clkCntQ  <= '0;
      rxShiftQ <= 8'h00;
      rxCntQ   <= 3'h0;
    end
    else if (!pauseIn && laneOk)
    begin
      if (clkCntQ != '1)
        clkCntQ <= clkCntQ + 1'b1;
      if (!driveNow)
      begin
        rxShiftQ <= rxNext;
        rxCntQ   <= rxSum[2:0];
      end
    end
  end

  // Byte handed over by toggle; it survives deselect so no event is lost
  always_ff @(posedge serialClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxByteQ <= 8'h00;
      rxTogQ  <= 1'b0;
    end
    else if (captureEn && rxSum[3])
    begin
      rxByteQ <= rxNext;
      rxTogQ  <= ~rxTogQ;
    end
  end

  // txDataQ is held stable by the empty handshake while the link reads it
  assign driveGo    = driveNow && laneOk && !holdHiQ && !chipSelectN && !hwPinLow;
  assign curByte    = (txCntQ == 3'h0) ? txDataQ : txShiftQ;
  assign curShifted = curByte << stepBits;
  assign txSum      = {1'b0, txCntQ} + {1'b0, stepBits};

  always_ff @(negedge serialClk or posedge linkClr)
  begin
    if (linkClr)
    begin
      txShiftQ <= 8'h00;
      txCntQ   <= 3'h0;
      driveQ   <= 1'b0;
      outQ     <= 4'h0;
    end
    else
    begin
      driveQ <= driveNow && laneOk;
      if (driveGo)
      begin
        txShiftQ <= curShifted;
        txCntQ   <= txSum[2:0];
        case (laneS)
          LANE_SINGLE: outQ <= {2'b00, curByte[7], 1'b0};
          LANE_DUAL:   outQ <= {2'b00, curByte[7:6]};
          LANE_QUAD:   outQ <= curByte[7:4];
          default:     outQ <= 4'h0;
        endcase
      end
    end
  end

  always_ff @(negedge serialClk or negedge rst_n)
  begin
    if (!rst_n)
      txTogQ <= 1'b0;
    else if (driveGo && (txCntQ == 3'h0))
      txTogQ <= ~txTogQ;
  end

  assign dataLineOut = outQ;
  assign dataLineOeN = ~(laneMask & {4{driveQ & ~chipSelectN & ~holdEff & ~hwPinLow}});

  sequence cfgWriteLocked;
    wrCfg && wpLocked;
  endsequence

  deselect_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    chipSelectN |-> (dataLineOeN == 4'hF))
    else $error("data line driven while deselected");
  arm_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rxValidQ) |-> $past(armedQ))
    else $error("byte accepted before first select fall");
  single_capture_a: assert property (@(posedge serialClk) disable iff (linkClr)
    (captureEn && laneS == LANE_SINGLE) |=> (rxShiftQ[0] == $past(dataLineIn[0])))
    else $error("serial input bit not captured");
  fall_drive_a: assert property (@(negedge serialClk) disable iff (linkClr)
    (driveGo && laneS == LANE_SINGLE) |-> ##1 (dataLineOut[1] == $past(curByte[7])))
    else $error("serial output not updated on falling edge");
  quad_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (dataLineOeN[3:2] != 2'b11) |-> quadEn)
    else $error("upper lines driven without quad enable");
  pause_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
    holdEff |-> (dataLineOeN == 4'hF))
    else $error("data line driven during pause");
  pause_freeze_a: assert property (@(posedge serialClk) disable iff (linkClr)
    pauseIn |=> ($stable(clkCntQ) && $stable(rxShiftQ)))
    else $error("shifter moved during pause");
  quad_no_pause_a: assert property (@(posedge mclk) disable iff (!rst_n)
    quadEn |-> (!holdEff && !hwPinLow))
    else $error("pause or reset active with quad enable");
  reset_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    hwRst |=> (!rxValidQ && !armedQ))
    else $error("state kept while reset pin low");
  protect_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgWriteLocked |=> $stable(cfgQ))
    else $error("status register written while protected");

endmodule // serial_flash_pin_interface

// *** tb/spi_host_model.sv ***
// SPI host model that drives the serial link of the flash pin front end
`timescale 1ns/100ps
module spi_host_model
(
  // Serial link towards the device
  output logic            serialClk,
  output logic            chipSelectN,
  output logic      [3:0] dataLineIn,
  input  wire logic [3:0] dataLineOut,
  input  wire logic [3:0] dataLineOeN,
  // Observations for the bench
  output logic            gotValid,
  output logic      [7:0] gotByte,
  output logic      [3:0] pauseOe
);
  logic [3:0] hostVal = 4'hC;
  logic [3:0] hostDrv = 4'hC;
  logic       flt     = 1'b0;

  initial
  begin
    serialClk   = 1'b0;
    chipSelectN = 1'b1;
    gotValid    = 1'b0;
    gotByte     = 8'h00;
    pauseOe     = 4'h0;
  end

  // Released lines keep changing so a stale bit never passes for data
  always #23 flt = ~flt;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dataLineIn[i] = !dataLineOeN[i] ? dataLineOut[i] : hostDrv[i] ? hostVal[i] : flt ^ i[0];
    end
  end

  task setPin(input int i, input logic v);
    hostVal[i] = v;
  endtask

  // One frame: nIn clocks inbound on w lanes, then nOut clocks read back
  task xfer(input bit m3, input int w, input int nIn, input int nOut, input logic [7:0] inB, input int pauseAt);
    logic [7:0] sh;
    logic [7:0] ob;
    sh = inB;
    ob = 8'h00;
    serialClk = m3;
    // Config is resynchronised on serial edges, so give a few while deselected
    repeat (2)
    begin
      #80 serialClk = ~serialClk;
      #80 serialClk = ~serialClk;
    end
    #37 chipSelectN = 1'b0;
    #80;
    for (int k = 0; k < nIn + nOut; k++)
    begin
      serialClk = 1'b0;
      // Pause pin moves inside the low half, never on a clock edge
      if (k == pauseAt)
      begin
        #40 hostVal[3] = 1'b0;
        #20 pauseOe = dataLineOeN;
        repeat (2)
        begin
          #80 serialClk = 1'b1;
          // Pause must also hold through the high half of the clock
          #40 pauseOe = pauseOe & dataLineOeN;
          #40 serialClk = 1'b0;
        end
        #40 hostVal[3] = 1'b1;
      end
      if (k < nIn)
      begin
        hostDrv = (w == 4) ? 4'hF : (w == 2) ? 4'hF : 4'hD;
        if (w == 1)
          hostVal[0] = sh[7];
        else if (w == 2)
          hostVal[1:0] = sh[7:6];
        else
          hostVal = sh[7:4];
        sh = sh << w;
      end
      else
        hostDrv = (w == 4) ? 4'h0 : 4'hC;
      #80 serialClk = 1'b1;
      if (k >= nIn)
        ob = (w == 1) ? {ob[6:0], dataLineIn[1]} : (w == 2) ? {ob[5:0], dataLineIn[1:0]} : {ob[3:0], dataLineIn};
      #80;
    end
    serialClk = m3;
    #80 chipSelectN = 1'b1;
    hostVal = 4'hC;
    hostDrv = 4'hC;
    if (nOut > 0)
    begin
      gotByte  = ob;
      gotValid = 1'b1;
      #1 gotValid = 1'b0;
    end
  endtask
endmodule // spi_host_model

// *** tb/serial_flash_pin_interface_tb_top.sv ***
// Self-checking testbench for the serial flash pin front end
`timescale 1ns/100ps
module serial_flash_pin_interface_tb_top;
  import flash_pin_pkg::*;

  logic              mclk;
  logic              rst_n;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic [DATA_W-1:0] regRdata;
  logic              regWr;
  logic              regRd;
  logic              serialClk;
  logic              chipSelectN;
  logic [3:0]        dataLineIn;
  logic [3:0]        dataLineOut;
  logic [3:0]        dataLineOeN;
  logic              gotValid;
  logic [7:0]        gotByte;
  logic [3:0]        pauseOe;
  int                num_errors   = 0;
  int                total_checks = 0;
  integer            seed         = 32'h255C;
  logic [DATA_W-1:0] regQ[$];
  logic [7:0]        serQ[$];
  logic              rdPend       = 1'b0;
  logic [DATA_W-1:0] r;
  logic [7:0]        b;
  logic [7:0]        t;

  serial_flash_pin_interface i_serial_flash_pin_interface (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .dataLineIn(dataLineIn), .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN));

  spi_host_model i_spi_host_model (.serialClk(serialClk), .chipSelectN(chipSelectN), .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN), .gotValid(gotValid), .gotByte(gotByte),
    .pauseOe(pauseOe));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task checkVal(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t register or pin value %h, expected %h", $time, got, exp);
    end
  endtask

  task checkSer(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t serial byte %h, expected %h", $time, got, exp);
    end
  endtask

  task regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask

  task regRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    regQ.push_back(exp);
    @(posedge mclk);
    regRd   <= 1'b0;
  endtask

  task setup(input logic [11:0] cfg, input logic [5:0] turn, output logic [7:0] tx);
    tx = 8'($random(seed));
    regWrite(CFG_ADDR, {20'h0, cfg});
    regWrite(TURN_ADDR, {26'h0, turn});
    regWrite(TX_ADDR, {24'h0, tx});
  endtask

  task frame(input bit m3, input int w, input int nIn, input int nOut, input logic [7:0] inB,
             input logic [7:0] txB, input int pauseAt);
    if (nOut > 0)
      serQ.push_back(txB);
    i_spi_host_model.xfer(m3, w, nIn, nOut, inB, pauseAt);
    repeat (8) @(posedge mclk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rdPend)
      checkVal(regRdata, regQ.pop_front());
    rdPend <= regRd;
  end

  always @(posedge gotValid)
    checkSer(gotByte, serQ.pop_front());

  task conclude;
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    num_errors++;
    conclude();
  end

  initial
  begin
    rst_n    = 1'b0;
    regAddr  = '0;
    regWdata = '0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    // Select synchroniser shows the real pin two edges after release
    @(posedge mclk);
    regRead(STAT_ADDR, 32'h20);
    regRead(CFG_ADDR, 32'h0);
    regRead(TURN_ADDR, 32'h0);
    regRead(5'h14, 32'h0);
    r = $random(seed);
    regWrite(CFG_ADDR, r);
    regRead(CFG_ADDR, {20'h0, r[11:0]});
    setup(12'h000, 6'h08, t);
    frame(1'b0, 1, 5, 0, 8'hA5, t, -1);
    b = 8'($random(seed));
    frame(1'b0, 1, 8, 8, b, t, -1);
    checkVal({28'h0, dataLineOeN}, 32'hF);
    regRead(STAT_ADDR, 32'h32);
    regRead(RX_ADDR, {24'h0, b});
    setup(12'h004, 6'h04, t);
    b = 8'($random(seed));
    frame(1'b1, 2, 4, 4, b, t, -1);
    regRead(RX_ADDR, {24'h0, b});
    setup(12'h009, 6'h02, t);
    b = 8'($random(seed));
    frame(1'b0, 4, 2, 2, b, t, -1);
    regRead(RX_ADDR, {24'h0, b});
    // Quad lanes without quad enable must capture nothing; the frame gives no read-back clocks
    setup(12'h008, 6'h02, t);
    frame(1'b0, 4, 2, 0, 8'hFF, t, -1);
    regRead(STAT_ADDR, 32'h02);
    regRead(RX_ADDR, {24'h0, b});
    setup(12'h000, 6'h08, t);
    b = 8'($random(seed));
    frame(1'b1, 1, 8, 8, b, t, 10);
    checkVal({28'h0, pauseOe}, 32'hF);
    regRead(RX_ADDR, {24'h0, b});
    regWrite(CFG_ADDR, 32'h10);
    i_spi_host_model.setPin(2, 1'b0);
    repeat (4) @(posedge mclk);
    regWrite(CFG_ADDR, 32'h0);
    regRead(CFG_ADDR, 32'h10);
    regRead(STAT_ADDR, 32'h62);
    i_spi_host_model.setPin(2, 1'b1);
    repeat (4) @(posedge mclk);
    regWrite(CFG_ADDR, 32'h2);
    regWrite(TX_ADDR, 32'h5A);
    i_spi_host_model.setPin(3, 1'b0);
    // Held past 1us, as the host must
    repeat (12) @(posedge mclk);
    regRead(STAT_ADDR, 32'h28);
    i_spi_host_model.setPin(3, 1'b1);
    repeat (4) @(posedge mclk);
    regWrite(CFG_ADDR, 32'h3);
    i_spi_host_model.setPin(3, 1'b0);
    repeat (4) @(posedge mclk);
    regRead(STAT_ADDR, 32'h20);
    i_spi_host_model.setPin(3, 1'b1);
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule // serial_flash_pin_interface_tb_top
